/* File: testbench/cpu_core_model.sv */
`timescale 1ns/1ns
// Core side: takes each standing offer after a chosen number of cycles
module cpu_core_model (
  input  wire logic              clk,       // System clock
  input  wire logic              rst,       // Async reset
  input  wire logic              exc_valid, // Offer standing
  input  wire interrupt_arbiter_pkg::vector_s vec,       // Offered vector
  input  wire logic [3:0]        ack_delay, // Wait before taking
  output logic                   cpu_ack,   // Take pulse
  output logic                   taken_stb, // Vector captured
  output interrupt_arbiter_pkg::vector_s      taken_vec  // Captured vector
);
  logic [3:0] wait_r;
  // Ack is held until the edge the arbiter samples it, vector taken there
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_ack <= 1'b0;
      taken_stb <= 1'b0;
      taken_vec <= '0;
      wait_r <= 4'h0;
    end else if (cpu_ack) begin
      cpu_ack <= 1'b0;
      taken_stb <= 1'b1;
      taken_vec <= vec;
      wait_r <= 4'h0;
    end else begin
      taken_stb <= 1'b0;
      if (exc_valid && wait_r >= ack_delay) cpu_ack <= 1'b1;
      else if (exc_valid) wait_r <= wait_r + 4'h1;
    end
  end
endmodule

/* File: testbench/interrupt_arbiter_checker.sv */
`timescale 1ns/1ns
// Ties the core-side outputs of the arbiter to their causes
module interrupt_arbiter_checker (
  input wire logic                          clk,                      // System clock
  input wire logic                          rst,                      // Async reset
  input wire logic                          cpu_ack,                  // Core takes offer
  input wire logic                          cpu_reti,                 // Service ends
  input wire logic [interrupt_arbiter_pkg::MASK_MAX-1:0] src_mask,                 // Source masks
  input wire logic                          exc_valid_r,              // Offer standing
  input wire interrupt_arbiter_pkg::vector_s             vec_r,                    // Offered vector
  input wire logic [31:0]                   exception_cause_register, // Cause
  input wire logic [7:0]                    in_service_r              // Levels in service
);
  logic [15:0]                   code_q;
  logic [interrupt_arbiter_pkg::MASK_MAX-1:0] mask_q;
  // Keeps code and masks one edge, so an outcome is judged against what caused it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_q <= 16'h0000;
      mask_q <= '0;
    end else begin
      code_q <= vec_r.code;
      mask_q <= src_mask;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ack; exc_valid_r && cpu_ack; endsequence
  sequence s_wait; exc_valid_r && !cpu_ack; endsequence
  offer_hold_a: assert property (s_wait |=> exc_valid_r && $stable(vec_r))
    else $error("offer changed before ack");
  ack_drop_a: assert property (s_ack |=> !exc_valid_r)
    else $error("offer kept after ack");
  cause_load_a: assert property (s_ack |=>
    exception_cause_register == {16'h0000, code_q})
    else $error("cause not loaded with code");
  reset_vec_a: assert property ($past(rst) && !rst |=> exc_valid_r
    && vec_r.code == 16'h0000 && vec_r.handler == 32'h0000_0000)
    else $error("no reset offer after release");
  trap_a_vec_a: assert property (exc_valid_r && vec_r.code[15:4] == 12'h004
    |-> vec_r.handler == 32'h0000_0040)
    else $error("first trap group handler wrong");
  trap_b_vec_a: assert property (exc_valid_r && vec_r.code[15:4] == 12'h005
    |-> vec_r.handler == 32'h0000_0050)
    else $error("second trap group handler wrong");
  fixed_vec_a: assert property (exc_valid_r
    && vec_r.code inside {16'h0010, 16'h0020, 16'h0060}
    |-> vec_r.handler == {16'h0000, vec_r.code})
    else $error("fixed handler wrong");
  mask_vec_a: assert property (exc_valid_r && vec_r.code >= 16'h0080
    |-> vec_r.handler == {16'h0000, vec_r.code})
    else $error("maskable handler differs from code");
  masked_src_a: assert property ($rose(exc_valid_r) && vec_r.code >= 16'h0080
    |-> !mask_q[6'((vec_r.code - 16'h0080) >> 4)])
    else $error("masked source offered");
  nest_set_a: assert property (s_ack and (vec_r.code >= 16'h0080 && !cpu_reti)
    |=> $countones(in_service_r) == $countones($past(in_service_r)) + 1)
    else $error("service level not recorded");
  reti_clear_a: assert property (cpu_reti && !cpu_ack && in_service_r != 8'h00
    |=> in_service_r == ($past(in_service_r) & ($past(in_service_r) - 8'h01)))
    else $error("return did not retire most urgent level");
endmodule

bind interrupt_arbiter interrupt_arbiter_checker u_checker (
  .clk(clk), .rst(rst), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .src_mask(src_mask),
  .exc_valid_r(exc_valid_r), .vec_r(vec_r), .exception_cause_register(exception_cause_register),
  .in_service_r(in_service_r));

/* File: testbench/interrupt_arbiter_tb_top.sv */
`timescale 1ns/1ns
module interrupt_arbiter_tb_top;
  logic clk, rst, irq_rst, nmi_pin, wdt, strap, ilg, dbg, reti, ack, stb, valid;
  logic [1:0] nmi_sel;
  logic [3:0] ack_wait;
  logic [4:0] tidx;
  logic [7:0] pins, ins;
  logic [15:0] pin_sel;
  logic [55:0] preq, mask;
  logic [167:0] lvl;
  logic [31:0] cause, cause_small;
  interrupt_arbiter_pkg::vector_s vec, took;
  int bad_count, samples_checked;

  interrupt_arbiter u_interrupt_arbiter (.clk(clk), .rst(rst), .internal_reset_req(irq_rst),
    .nmi_pin(nmi_pin), .nmi_edge_sel(nmi_sel), .watchdog_overflow_request(wdt),
    .ext_pin(pins), .ext_edge_sel(pin_sel), .periph_req(preq), .src_mask(mask),
    .src_level(lvl), .soft_trap_req(strap), .soft_trap_index(tidx),
    .illegal_opcode_trap(ilg), .debug_trap(dbg), .cpu_ack(ack), .cpu_reti(reti),
    .exc_valid_r(valid), .vec_r(vec), .exception_cause_register(cause), .in_service_r(ins));
  // Smallest variant takes every offer at once, so only its cause tells what it saw
  interrupt_arbiter #(.VARIANT(0)) u_interrupt_arbiter_small (.clk(clk), .rst(rst),
    .internal_reset_req(irq_rst), .nmi_pin(nmi_pin), .nmi_edge_sel(nmi_sel),
    .watchdog_overflow_request(wdt), .ext_pin(pins), .ext_edge_sel(pin_sel),
    .periph_req(preq), .src_mask(mask), .src_level(lvl), .soft_trap_req(strap),
    .soft_trap_index(tidx), .illegal_opcode_trap(ilg), .debug_trap(dbg), .cpu_ack(1'b1),
    .cpu_reti(1'b1), .exc_valid_r(), .vec_r(), .exception_cause_register(cause_small),
    .in_service_r());
  cpu_core_model u_cpu_core_model (.clk(clk), .rst(rst), .exc_valid(valid), .vec(vec),
    .ack_delay(ack_wait), .cpu_ack(ack), .taken_stb(stb), .taken_vec(took));

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic step();
    @(posedge clk);
    #5;
  endtask
  task automatic fail(string m);
    bad_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic pulse(ref logic s);
    step();
    s = 1'b1;
    step();
    s = 1'b0;
  endtask
  task automatic preq_pulse(logic [55:0] v);
    step();
    preq = v;
    step();
    preq = '0;
  endtask
  // Waits a bounded time for the core to take a vector, then checks it and the cause
  task automatic expect_take(logic [15:0] c, logic [31:0] h);
    int i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (stb !== 1'b1 && i < 100);
    samples_checked++;
    if (stb !== 1'b1 || took.code !== c || took.handler !== h || cause !== {16'h0000, c})
      fail($sformatf("took %h/%h want %h/%h", took.code, took.handler, c, h));
  endtask
  task automatic quiet(int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      samples_checked++;
      if (valid !== 1'b0) fail("offer not held back");
    end
  endtask
  task automatic chk_ins(logic [7:0] e);
    samples_checked++;
    if (ins !== e) fail($sformatf("in service %h want %h", ins, e));
  endtask

  // Non-maskable sources ignore every mask; all trap numbers; slow core
  task automatic t_exc();
    step();
    mask = '1;
    ack_wait = 4'h5;
    nmi_sel = interrupt_arbiter_pkg::EDGE_RISE;
    step();
    nmi_pin = 1'b1;
    expect_take(16'h0010, 32'h0000_0010);
    step();
    nmi_pin = 1'b0;
    quiet(12);
    pulse(wdt);
    expect_take(16'h0020, 32'h0000_0020);
    pulse(ilg);
    expect_take(16'h0060, 32'h0000_0060);
    pulse(dbg);
    expect_take(16'h0060, 32'h0000_0060);
    for (int t = 0; t < 32; t++) begin
      step();
      tidx = 5'(t);
      strap = 1'b1;
      step();
      strap = 1'b0;
      expect_take({11'h002, tidx}, t < 16 ? 32'h0000_0040 : 32'h0000_0050);
    end
    step();
    mask = '0;
    ack_wait = 4'h0;
  endtask
  // A masked source stays pending and is offered once unmasked
  task automatic t_mask();
    preq_pulse(56'h00_0000_0000_0200);
    expect_take(16'h0110, 32'h0000_0110);
    pulse(reti);
    step();
    mask = 56'h00_0000_0000_0400;
    preq_pulse(56'h00_0000_0000_0400);
    quiet(10);
    step();
    mask = '0;
    expect_take(16'h0120, 32'h0000_0120);
    chk_ins(8'h01);
    pulse(reti);
    quiet(2);
    chk_ins(8'h00);
  endtask
  // Equal levels by index, equal level waits, more urgent level nests
  task automatic t_prio();
    logic [167:0] l = '0;
    l[60 +: 3] = 3'h3;
    l[90 +: 3] = 3'h3;
    l[120 +: 3] = 3'h1;
    step();
    lvl = l;
    preq_pulse(56'h00_0000_4010_0000);
    expect_take(16'h01C0, 32'h0000_01C0);
    quiet(8);
    preq_pulse(56'h00_0100_0000_0000);
    expect_take(16'h0300, 32'h0000_0300);
    chk_ins(8'h0A);
    pulse(reti);
    quiet(6);
    pulse(reti);
    expect_take(16'h0260, 32'h0000_0260);
    pulse(reti);
  endtask
  // Pin filter drops a glitch and honours the selected edge
  task automatic t_pins();
    step();
    pin_sel = 16'h0023;
    step();
    pins = 8'h04;
    quiet(12);
    step();
    pins = 8'h00;
    step();
    pins = 8'h04;
    quiet(12);
    step();
    pins = 8'h00;
    expect_take(16'h00B0, 32'h0000_00B0);
    pulse(reti);
    step();
    pins = 8'h01;
    expect_take(16'h0090, 32'h0000_0090);
    pulse(reti);
  endtask

  // Sources past the small total never pend there, while the large variant offers them
  task automatic t_variant();
    preq_pulse(56'h00_4000_0000_0000);
    expect_take(16'h0360, 32'h0000_0360);
    samples_checked++;
    if (cause_small !== 32'h0000_0360) fail("small variant lost present source");
    pulse(reti);
    preq_pulse(56'h00_8000_0000_0000);
    expect_take(16'h0370, 32'h0000_0370);
    samples_checked++;
    if (cause_small !== 32'h0000_0360) fail("small variant took absent source");
    pulse(reti);
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    {irq_rst, nmi_pin, wdt, strap, ilg, dbg, reti, nmi_sel, ack_wait, tidx} = '0;
    {pins, pin_sel, preq, mask, lvl} = '0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #5 rst = 1'b0;
    expect_take(16'h0000, 32'h0000_0000);
    pulse(irq_rst);
    expect_take(16'h0000, 32'h0000_0000);
    t_exc();
    t_mask();
    t_prio();
    t_pins();
    t_variant();
    final_report();
  end
  // Cuts a hang short well past the expected run length
  initial begin
    #3000000;
    fail("run did not finish");
    final_report();
  end
endmodule

/* File: verilog/interrupt_arbiter.sv */
`timescale 1ns/1ns
module interrupt_arbiter #(
  parameter int VARIANT  = 2,                     // 0, 1 or 2 selects the source total
  parameter int FILT_LEN = interrupt_arbiter_pkg::FILTER_LEN   // Pin filter window in clocks
) (
  input  wire logic                                        clk,           // System clock
  input  wire logic                                        rst,           // Async reset
  input  wire logic                                        internal_reset_req, // Reset pulse
  input  wire logic                                        nmi_pin,       // NMI pin level
  input  wire logic [1:0]                                  nmi_edge_sel,  // NMI valid edge
  input  wire logic                                        watchdog_overflow_request, // Pulse
  input  wire logic [interrupt_arbiter_pkg::EXT_PIN_NUM-1:0]            ext_pin,       // External pins
  input  wire logic [2*interrupt_arbiter_pkg::EXT_PIN_NUM-1:0]          ext_edge_sel,  // Edge per pin
  input  wire logic [interrupt_arbiter_pkg::MASK_MAX-1:0]               periph_req,    // Peripheral pulses
  input  wire logic [interrupt_arbiter_pkg::MASK_MAX-1:0]               src_mask,      // 1 blocks source
  input  wire logic [interrupt_arbiter_pkg::MASK_MAX*interrupt_arbiter_pkg::PRIO_W-1:0] src_level,  // 0 is highest
  input  wire logic                                        soft_trap_req, // Trap pulse
  input  wire logic [interrupt_arbiter_pkg::TRAP_IDX_W-1:0]             soft_trap_index, // Trap number
  input  wire logic                                        illegal_opcode_trap, // Pulse
  input  wire logic                                        debug_trap,    // Pulse
  input  wire logic                                        cpu_ack,       // CPU takes offer
  input  wire logic                                        cpu_reti,      // Service ends
  output logic                                             exc_valid_r,   // Offer standing
  output interrupt_arbiter_pkg::vector_s                                vec_r,         // Code and handler
  output logic [31:0]                                      exception_cause_register, // Cause
  output logic [interrupt_arbiter_pkg::NUM_LEVELS-1:0]                  in_service_r   // Levels in service
);
  localparam int TOTAL   = (VARIANT == 0) ? interrupt_arbiter_pkg::TOTAL_SMALL :
                           (VARIANT == 1) ? interrupt_arbiter_pkg::TOTAL_MID : interrupt_arbiter_pkg::TOTAL_LARGE;
  localparam int PRESENT = TOTAL - interrupt_arbiter_pkg::NONMASK_SRC;

  logic [interrupt_arbiter_pkg::EXT_PIN_NUM-1:0] ext_pulse;
  logic                              nmi_pulse;
  logic [interrupt_arbiter_pkg::MASK_MAX-1:0]     src_event;
  logic [interrupt_arbiter_pkg::MASK_MAX-1:0]     present_mask;

  // Filter every external line through the same edge stage
  genvar g;
  generate
    for (g = 0; g < interrupt_arbiter_pkg::EXT_PIN_NUM; g++) begin : g_pin
      pin_edge_filter #(.FILT_LEN(FILT_LEN)) u_filt (
        .clk      (clk),
        .rst      (rst),
        .pin      (ext_pin[g]),
        .edge_sel (ext_edge_sel[2*g+1:2*g]),
        .pulse_r  (ext_pulse[g])
      );
    end
    for (g = 0; g < interrupt_arbiter_pkg::MASK_MAX; g++) begin : g_src
      // Pins replace the peripheral line at default priorities 1 to 8
      if (g >= interrupt_arbiter_pkg::EXT_FIRST_SRC && g < interrupt_arbiter_pkg::EXT_FIRST_SRC + interrupt_arbiter_pkg::EXT_PIN_NUM)
      begin : g_ext
        assign src_event[g] = ext_pulse[g-interrupt_arbiter_pkg::EXT_FIRST_SRC];
      end else begin : g_per
        assign src_event[g] = periph_req[g];
      end
      assign present_mask[g] = (g < PRESENT);
    end
  endgenerate

  pin_edge_filter #(.FILT_LEN(FILT_LEN)) u_nmi_filt (
    .clk      (clk),
    .rst      (rst),
    .pin      (nmi_pin),
    .edge_sel (nmi_edge_sel),
    .pulse_r  (nmi_pulse)
  );

  // Pending and offer state
  logic [interrupt_arbiter_pkg::MASK_MAX-1:0]   pend_r, pend_nxt;
  logic                            rst_pend_r, rst_pend_nxt;
  logic                            nmi_pend_r, nmi_pend_nxt;
  logic                            wdt_pend_r, wdt_pend_nxt;
  logic                            trap_pend_r, trap_pend_nxt;
  logic [interrupt_arbiter_pkg::TRAP_IDX_W-1:0] trap_idx_r, trap_idx_nxt;
  logic                            trapx_pend_r, trapx_pend_nxt;
  interrupt_arbiter_pkg::offer_e                state_r, state_nxt;
  interrupt_arbiter_pkg::kind_e                 kind_r, kind_nxt;
  logic [interrupt_arbiter_pkg::IDX_W-1:0]      idx_r, idx_nxt;
  logic                            valid_nxt;
  interrupt_arbiter_pkg::vector_s               vec_nxt;
  logic [31:0]                     cause_nxt;
  logic [interrupt_arbiter_pkg::NUM_LEVELS-1:0] isr_nxt;

  // Arbitration scratch
  logic                            best_hit;
  logic [interrupt_arbiter_pkg::IDX_W-1:0]      best_idx;
  logic [interrupt_arbiter_pkg::PRIO_W:0]       best_lvl;
  logic [interrupt_arbiter_pkg::PRIO_W:0]       cur_lvl;
  logic [interrupt_arbiter_pkg::PRIO_W:0]       lvl_i;
  logic [interrupt_arbiter_pkg::MASK_MAX-1:0]   mask_clr;
  logic [interrupt_arbiter_pkg::NUM_LEVELS-1:0] isr_work;

  // Next-state logic: event capture, winner choice, offer and acknowledge
  always_comb begin
    mask_clr       = '0;
    rst_pend_nxt   = rst_pend_r;
    nmi_pend_nxt   = nmi_pend_r;
    wdt_pend_nxt   = wdt_pend_r;
    trap_pend_nxt  = trap_pend_r;
    trap_idx_nxt   = trap_idx_r;
    trapx_pend_nxt = trapx_pend_r;
    state_nxt      = state_r;
    kind_nxt       = kind_r;
    idx_nxt        = idx_r;
    valid_nxt      = exc_valid_r;
    vec_nxt        = vec_r;
    cause_nxt      = exception_cause_register;
    isr_work       = in_service_r;
    best_hit       = 1'b0;
    best_idx       = '0;
    best_lvl       = interrupt_arbiter_pkg::PRIO_W'(0) + (interrupt_arbiter_pkg::PRIO_W+1)'(interrupt_arbiter_pkg::LEVEL_NONE);
    cur_lvl        = (interrupt_arbiter_pkg::PRIO_W+1)'(interrupt_arbiter_pkg::LEVEL_NONE);

    // End of service retires the most urgent level in service
    for (int l = interrupt_arbiter_pkg::NUM_LEVELS - 1; l >= 0; l--) begin
      if (in_service_r[l]) begin
        cur_lvl = (interrupt_arbiter_pkg::PRIO_W+1)'(l);
      end
    end
    if (cpu_reti && cur_lvl != (interrupt_arbiter_pkg::PRIO_W+1)'(interrupt_arbiter_pkg::LEVEL_NONE)) begin
      isr_work[cur_lvl[interrupt_arbiter_pkg::PRIO_W-1:0]] = 1'b0;
    end

    // Strict less-than keeps the lowest index on a level tie
    for (int i = 0; i < interrupt_arbiter_pkg::MASK_MAX; i++) begin
      lvl_i = {1'b0, src_level[i*interrupt_arbiter_pkg::PRIO_W +: interrupt_arbiter_pkg::PRIO_W]};
      if (pend_r[i] && !src_mask[i] && lvl_i < best_lvl) begin
        best_lvl = lvl_i;
        best_idx = interrupt_arbiter_pkg::IDX_W'(i);
      end
    end
    best_hit = (best_lvl < cur_lvl);

    unique case (state_r)
      interrupt_arbiter_pkg::ST_IDLE: begin
        // Fixed precedence: reset, pin NMI, watchdog, traps, then maskable
        state_nxt = interrupt_arbiter_pkg::ST_OFFER;
        valid_nxt = 1'b1;
        if (rst_pend_r) begin
          kind_nxt = interrupt_arbiter_pkg::K_RESET;
          vec_nxt  = '{code: interrupt_arbiter_pkg::CODE_RESET, handler: interrupt_arbiter_pkg::ADDR_RESET};
        end else if (nmi_pend_r) begin
          kind_nxt = interrupt_arbiter_pkg::K_NMI;
          vec_nxt  = '{code: interrupt_arbiter_pkg::CODE_NMI, handler: interrupt_arbiter_pkg::ADDR_NMI};
        end else if (wdt_pend_r) begin
          kind_nxt = interrupt_arbiter_pkg::K_WDT;
          vec_nxt  = '{code: interrupt_arbiter_pkg::CODE_WDT, handler: interrupt_arbiter_pkg::ADDR_WDT};
        end else if (trap_pend_r) begin
          kind_nxt = interrupt_arbiter_pkg::K_TRAP;
          if (trap_idx_r[interrupt_arbiter_pkg::TRAP_IDX_W-1]) begin
            vec_nxt = '{code: interrupt_arbiter_pkg::CODE_TRAP_B | {12'h000, trap_idx_r[3:0]},
                        handler: interrupt_arbiter_pkg::ADDR_TRAP_B};
          end else begin
            vec_nxt = '{code: interrupt_arbiter_pkg::CODE_TRAP_A | {12'h000, trap_idx_r[3:0]},
                        handler: interrupt_arbiter_pkg::ADDR_TRAP_A};
          end
        end else if (trapx_pend_r) begin
          kind_nxt = interrupt_arbiter_pkg::K_TRAPX;
          vec_nxt  = '{code: interrupt_arbiter_pkg::CODE_TRAPX, handler: interrupt_arbiter_pkg::ADDR_TRAPX};
        end else if (best_hit) begin
          kind_nxt     = interrupt_arbiter_pkg::K_MASK;
          idx_nxt      = best_idx;
          vec_nxt.code = interrupt_arbiter_pkg::CODE_MASK0 + 16'(best_idx) * interrupt_arbiter_pkg::CODE_STEP;
          vec_nxt.handler = {16'h0000, vec_nxt.code};
        end else begin
          state_nxt = interrupt_arbiter_pkg::ST_IDLE;
          valid_nxt = 1'b0;
        end
      end
      interrupt_arbiter_pkg::ST_OFFER: begin
        if (cpu_ack) begin
          state_nxt = interrupt_arbiter_pkg::ST_IDLE;
          valid_nxt = 1'b0;
          cause_nxt = {16'h0000, vec_r.code};
          unique case (kind_r)
            interrupt_arbiter_pkg::K_RESET: rst_pend_nxt   = 1'b0;
            interrupt_arbiter_pkg::K_NMI:   nmi_pend_nxt   = 1'b0;
            interrupt_arbiter_pkg::K_WDT:   wdt_pend_nxt   = 1'b0;
            interrupt_arbiter_pkg::K_TRAP:  trap_pend_nxt  = 1'b0;
            interrupt_arbiter_pkg::K_TRAPX: trapx_pend_nxt = 1'b0;
            interrupt_arbiter_pkg::K_MASK: begin
              mask_clr[idx_r] = 1'b1;
              isr_work[src_level[idx_r*interrupt_arbiter_pkg::PRIO_W +: interrupt_arbiter_pkg::PRIO_W]] = 1'b1;
            end
            default: ;
          endcase
        end
      end
    endcase

    // New events are applied last so a set wins over a same-cycle clear
    if (internal_reset_req) begin
      rst_pend_nxt = 1'b1;
    end
    if (nmi_pulse) begin
      nmi_pend_nxt = 1'b1;
    end
    if (watchdog_overflow_request) begin
      wdt_pend_nxt = 1'b1;
    end
    if (soft_trap_req) begin
      trap_pend_nxt = 1'b1;
      trap_idx_nxt  = soft_trap_index;
    end
    if (illegal_opcode_trap || debug_trap) begin
      trapx_pend_nxt = 1'b1;
    end
    pend_nxt = ((pend_r & ~mask_clr) | src_event) & present_mask;
    isr_nxt  = isr_work;
  end

  // Reset itself leaves a reset exception pending for the core
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r                   <= '0;
      rst_pend_r               <= 1'b1;
      nmi_pend_r               <= 1'b0;
      wdt_pend_r               <= 1'b0;
      trap_pend_r              <= 1'b0;
      trap_idx_r               <= '0;
      trapx_pend_r             <= 1'b0;
      state_r                  <= interrupt_arbiter_pkg::ST_IDLE;
      kind_r                   <= interrupt_arbiter_pkg::K_RESET;
      idx_r                    <= '0;
      exc_valid_r              <= 1'b0;
      vec_r                    <= '0;
      exception_cause_register <= '0;
      in_service_r             <= '0;
    end else begin
      pend_r                   <= pend_nxt;
      rst_pend_r               <= rst_pend_nxt;
      nmi_pend_r               <= nmi_pend_nxt;
      wdt_pend_r               <= wdt_pend_nxt;
      trap_pend_r              <= trap_pend_nxt;
      trap_idx_r               <= trap_idx_nxt;
      trapx_pend_r             <= trapx_pend_nxt;
      state_r                  <= state_nxt;
      kind_r                   <= kind_nxt;
      idx_r                    <= idx_nxt;
      exc_valid_r              <= valid_nxt;
      vec_r                    <= vec_nxt;
      exception_cause_register <= cause_nxt;
      in_service_r             <= isr_nxt;
    end
  end
endmodule

/* File: verilog/interrupt_arbiter_pkg.sv */
package interrupt_arbiter_pkg;
  // Priority and source counts
  localparam int PRIO_W        = 3;
  localparam int NUM_LEVELS    = 8;
  localparam int LEVEL_NONE    = 8;    // Threshold when nothing is in service
  localparam int TOTAL_SMALL   = 49;   // Source totals per package variant
  localparam int TOTAL_MID     = 53;
  localparam int TOTAL_LARGE   = 58;
  localparam int NONMASK_SRC   = 2;    // Pin non-maskable plus watchdog
  localparam int MASK_MAX      = TOTAL_LARGE - NONMASK_SRC;
  localparam int IDX_W         = 6;
  localparam int EXT_PIN_NUM   = 8;
  localparam int EXT_FIRST_SRC = 1;    // External pins occupy default priorities 1 to 8
  localparam int FILTER_LEN    = 3;    // Samples that must agree before a level is accepted
  localparam int TRAP_IDX_W    = 5;

  // Exception codes and handler addresses
  localparam logic [15:0] CODE_RESET   = 16'h0000;
  localparam logic [15:0] CODE_NMI     = 16'h0010;
  localparam logic [15:0] CODE_WDT     = 16'h0020;
  localparam logic [15:0] CODE_TRAP_A  = 16'h0040;
  localparam logic [15:0] CODE_TRAP_B  = 16'h0050;
  localparam logic [15:0] CODE_TRAPX   = 16'h0060;
  localparam logic [15:0] CODE_MASK0   = 16'h0080;
  localparam logic [15:0] CODE_STEP    = 16'h0010;
  localparam logic [31:0] ADDR_RESET   = 32'h0000_0000;
  localparam logic [31:0] ADDR_NMI     = 32'h0000_0010;
  localparam logic [31:0] ADDR_WDT     = 32'h0000_0020;
  localparam logic [31:0] ADDR_TRAP_A  = 32'h0000_0040;
  localparam logic [31:0] ADDR_TRAP_B  = 32'h0000_0050;
  localparam logic [31:0] ADDR_TRAPX   = 32'h0000_0060;

  // Valid edge selection for external pins
  localparam logic [1:0] EDGE_NONE    = 2'h0;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;

  typedef struct packed {
    logic [15:0] code;
    logic [31:0] handler;
  } vector_s;

  typedef enum logic {ST_IDLE, ST_OFFER} offer_e;
  typedef enum logic [2:0] {K_RESET, K_NMI, K_WDT, K_TRAP, K_TRAPX, K_MASK} kind_e;
endpackage

/* File: verilog/pin_edge_filter.sv */
`timescale 1ns/1ns
// Noise filter and valid-edge detector for one external request pin
module pin_edge_filter #(
  parameter int FILT_LEN = interrupt_arbiter_pkg::FILTER_LEN
) (
  input  wire logic       clk,      // System clock
  input  wire logic       rst,      // Async reset, active high
  input  wire logic       pin,      // Raw pin level
  input  wire logic [1:0] edge_sel, // Which edge counts
  output logic            pulse_r   // One-cycle valid-edge pulse
);
  logic [FILT_LEN-1:0] samp_r;
  logic [FILT_LEN-1:0] samp_nxt;
  logic                level_r;
  logic                level_nxt;
  logic                pulse_nxt;

  // Level only changes once all samples agree, so glitches shorter than the window vanish
  always_comb begin
    samp_nxt  = {samp_r[FILT_LEN-2:0], pin};
    level_nxt = level_r;
    pulse_nxt = 1'b0;
    if (&samp_r) begin
      level_nxt = 1'b1;
    end else if (~|samp_r) begin
      level_nxt = 1'b0;
    end
    if (level_nxt & ~level_r) begin
      pulse_nxt = edge_sel[0];
    end else if (~level_nxt & level_r) begin
      pulse_nxt = edge_sel[1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      samp_r  <= '0;
      level_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      samp_r  <= samp_nxt;
      level_r <= level_nxt;
      pulse_r <= pulse_nxt;
    end
  end
endmodule
